// ### src/dmsp_port.sv
// Functional notes
// - in character mode each bit on the data line lasts 372 carrier clock periods.
// - in two-wire mode incoming bits are sampled on the rising serial clock edge.
// - in two-wire mode read data is driven after the falling serial clock edge.
// - a reset activation in character mode sends the eight bytes of the 64-bit reset answer.
// - no reset answer is ever sent while in two-wire mode.
// - an unwired reset input reads inactive through the pull-up.
// - the data line is open-drain, only pulled low or released, with an external pull-up.
// - writes are single bytes or pages of up to 16 bytes, finished by a self-timed cycle.
// - up to 15 devices share the bus and each answers only its own address.
// - user memory is four 64-byte zones, each with its own access rights.
// - configuration holds eight sets of two 24-bit passwords and four key sets.
// - data may change only while the serial clock is low, else it is a start or stop.
`timescale 1ns/10ps
module dmsp_port #(
    parameter int unsigned WR_CYCLES = dmsp_pkg::WR_CYCLES_DEF
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       link_clk_i,
    input  wire logic       rst_pin_i,
    input  wire logic       sda_i,
    input  wire logic [3:0] dev_addr_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            busy_o,
    output logic            async_mode_o,
    output logic            sync_mode_o
);
    import dmsp_pkg::*;

    function automatic logic [8:0] mem_idx(input logic space, input logic [7:0] a);
        mem_idx = space ? (9'(USER_BYTES) + {2'b00, a[6:0]}) : {1'b0, a};
    endfunction

    // configuration layout: reset answer, zone access, passwords, keys
    function automatic logic [7:0] init_byte(input int i);
        int c;
        c = i - int'(USER_BYTES);
        init_byte = 8'h00;
        if (c >= int'(CFG_ANS) && c < int'(CFG_ANS + ANS_BYTES)) begin
            init_byte = ANS_RST[8*(c-int'(CFG_ANS)) +: 8];
        end else if (c >= int'(CFG_ACCESS) && c < int'(CFG_ACCESS + ZONES)) begin
            init_byte = ACCESS_RST;
        end else if (c >= int'(CFG_PWD) && c < int'(CFG_KEY + KEY_SETS * KEY_BYTES)) begin
            init_byte = 8'h00;
        end
    endfunction

    function automatic logic frame_bit(input logic [7:0] d, input logic [3:0] n);
        case (n)
            4'h0:    frame_bit = 1'b0;
            4'h9:    frame_bit = ^d;
            4'ha,
            4'hb:    frame_bit = 1'b1;
            default: frame_bit = d[3'(n - 4'h1)];
        endcase
    endfunction

    // pin sampling
    wire  [2:0] pin_raw = {rst_pin_i, sda_i, link_clk_i};
    logic [2:0] pin_l;
    logic [2:0] pin_d_r;

    generate
        for (genvar g = 0; g < 3; g++) begin : g_pin
            dmsp_sync3 #(.RST_VAL(PIN_RST_VAL[g])) u_sync (
                .clk_i    (clk_i),
                .resetn_i (resetn_i),
                .d_i      (pin_raw[g]),
                .lvl_o    (pin_l[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_d_r <= PIN_RST_VAL;
        end else begin
            pin_d_r <= pin_l;
        end
    end

    wire scl_l     = pin_l[PIN_SCL];
    wire sda_l     = pin_l[PIN_SDA];
    wire rst_l     = pin_l[PIN_RST];
    wire scl_rise  = scl_l & ~pin_d_r[PIN_SCL];
    wire scl_fall  = ~scl_l & pin_d_r[PIN_SCL];
    wire scl_high  = scl_l & pin_d_r[PIN_SCL];
    wire rst_rise  = rst_l & ~pin_d_r[PIN_RST];
    wire bus_start = scl_high & pin_d_r[PIN_SDA] & ~sda_l;
    wire bus_stop  = scl_high & ~pin_d_r[PIN_SDA] & sda_l;

    // operating mode
    dmsp_mode_type mode_r;
    dmsp_mode_type mode_nxt;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_NONE: begin
                if (!rst_l) begin
                    mode_nxt = MODE_ASYNC;
                end else if (bus_start) begin
                    mode_nxt = MODE_SYNC;
                end
            end
            MODE_ASYNC: mode_nxt = MODE_ASYNC;
            MODE_SYNC:  mode_nxt = MODE_SYNC;
            default:    mode_nxt = MODE_NONE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= MODE_NONE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    wire is_async = (mode_r == MODE_ASYNC);
    wire tw_run   = (mode_r != MODE_ASYNC);

    // storage
    logic [7:0] mem_r [0:MEM_BYTES-1];
    logic [7:0] page_r [0:PAGE_BYTES-1];
    logic [15:0] mask_r;
    logic [7:0]  pbase_r;
    logic        pspace_r;
    logic [3:0]  plo_r;
    logic        busy_r;
    logic        pend_r;
    logic [31:0] wr_cnt_r;

    // reset answer engine
    dmsp_atr_type at_st_r;
    logic [8:0]   unit_cnt_r;
    logic [3:0]   at_bit_r;
    logic [2:0]   at_byte_r;
    logic         at_oe_r;

    wire [7:0] ans_data = mem_r[mem_idx(1'b1, 8'(CFG_ANS) + {5'h00, at_byte_r})];
    wire       unit_end = (unit_cnt_r == UNIT_CARRIER - 9'h001);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            at_st_r    <= AT_IDLE;
            unit_cnt_r <= 9'h000;
            at_bit_r   <= 4'h0;
            at_byte_r  <= 3'h0;
        end else if (!is_async || !rst_l) begin
            at_st_r <= AT_IDLE;
        end else begin
            case (at_st_r)
                AT_IDLE: begin
                    if (rst_rise) begin
                        at_st_r    <= AT_WAIT;
                        unit_cnt_r <= 9'h000;
                    end
                end
                AT_WAIT: begin
                    if (scl_rise) begin
                        unit_cnt_r <= unit_cnt_r + 9'h001;
                        if (unit_cnt_r == ANS_DELAY - 9'h001) begin
                            at_st_r    <= AT_SEND;
                            unit_cnt_r <= 9'h000;
                            at_bit_r   <= 4'h0;
                            at_byte_r  <= 3'h0;
                        end
                    end
                end
                AT_SEND: begin
                    if (scl_rise) begin
                        unit_cnt_r <= unit_end ? 9'h000 : unit_cnt_r + 9'h001;
                        if (unit_end && at_bit_r == FRAME_BITS - 4'h1) begin
                            at_bit_r  <= 4'h0;
                            at_byte_r <= at_byte_r + 3'h1;
                            if (at_byte_r == ANS_LAST_BYTE) begin
                                at_st_r <= AT_END;
                            end
                        end else if (unit_end) begin
                            at_bit_r <= at_bit_r + 4'h1;
                        end
                    end
                end
                AT_END:  at_st_r <= AT_END;
                default: at_st_r <= AT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            at_oe_r <= 1'b0;
        end else begin
            at_oe_r <= (at_st_r == AT_SEND) & ~frame_bit(ans_data, at_bit_r);
        end
    end

    // two-wire engine
    dmsp_tw_type  tw_st_r;
    logic [3:0]   bitn_r;
    logic [7:0]   sreg_r;
    logic [1:0]   bcnt_r;
    logic         rd_r;
    logic         space_r;
    logic [7:0]   addr_r;
    logic         ack_r;
    logic         tw_oe_r;
    logic         buf_in_ready;
    logic         buf_out_valid;
    logic [7:0]   buf_out_data;

    wire [7:0] byte_in  = {sreg_r[6:0], sda_l};
    wire [7:0] rd_acc   = mem_r[mem_idx(1'b1, 8'(CFG_ACCESS) + {6'h00, addr_r[7:6]})];
    wire [7:0] wr_acc   = mem_r[mem_idx(1'b1, 8'(CFG_ACCESS) + {6'h00, pbase_r[7:6]})];
    wire       rd_ok    = space_r | rd_acc[ACC_RD_BIT];
    wire       wr_ok    = pspace_r | wr_acc[ACC_WR_BIT];
    wire [7:0] rd_byte  = rd_ok ? mem_r[mem_idx(space_r, addr_r)] : READ_DENIED;
    wire       last_bit = (tw_st_r == TW_RX) & scl_rise & (bitn_r == 4'h7);
    wire       addr_ld  = last_bit & (bcnt_r == 2'h1);
    wire       buf_push = last_bit & (bcnt_r == 2'h2) & ~rd_r;
    wire       dev_hit  = (byte_in[7:DEVB_ADDR_LO] == dev_addr_i)
                          & (dev_addr_i != DEV_ADDR_NONE) & ~busy_r & ~pend_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tw_st_r <= TW_IDLE;
            bitn_r  <= 4'h0;
            sreg_r  <= 8'h00;
            bcnt_r  <= 2'h0;
            rd_r    <= 1'b0;
            space_r <= 1'b0;
            addr_r  <= 8'h00;
            ack_r   <= 1'b0;
            tw_oe_r <= 1'b0;
        end else if (!tw_run) begin
            tw_st_r <= TW_IDLE;
            tw_oe_r <= 1'b0;
        end else if (bus_start) begin
            tw_st_r <= TW_RX;
            bitn_r  <= 4'h0;
            bcnt_r  <= 2'h0;
            tw_oe_r <= 1'b0;
        end else if (bus_stop) begin
            tw_st_r <= TW_IDLE;
            tw_oe_r <= 1'b0;
        end else begin
            case (tw_st_r)
                TW_RX: begin
                    if (scl_rise && bitn_r < 4'h8) begin
                        sreg_r <= byte_in;
                        bitn_r <= bitn_r + 4'h1;
                    end else if (scl_rise) begin
                        bitn_r <= 4'h9;
                    end
                    if (last_bit) begin
                        case (bcnt_r)
                            2'h0: begin
                                ack_r   <= dev_hit;
                                rd_r    <= byte_in[DEVB_RD];
                                space_r <= byte_in[DEVB_SPACE];
                            end
                            2'h1: begin
                                ack_r  <= 1'b1;
                                addr_r <= byte_in;
                            end
                            default: ack_r <= ~rd_r & buf_in_ready;
                        endcase
                    end
                    if (scl_fall && bitn_r == 4'h8) begin
                        tw_oe_r <= ack_r;
                    end else if (scl_fall && bitn_r == 4'h9) begin
                        tw_oe_r <= 1'b0;
                        bitn_r  <= 4'h0;
                        if (!ack_r) begin
                            tw_st_r <= TW_IDLE;
                        end else if (bcnt_r == 2'h0 && rd_r) begin
                            tw_st_r <= TW_TX;
                            sreg_r  <= rd_byte;
                            addr_r  <= addr_r + 8'h01;
                            tw_oe_r <= ~rd_byte[7];
                        end else if (bcnt_r != 2'h2) begin
                            bcnt_r <= bcnt_r + 2'h1;
                        end
                    end
                end
                TW_TX: begin
                    if (scl_rise && bitn_r < 4'h8) begin
                        sreg_r <= {sreg_r[6:0], 1'b0};
                        bitn_r <= bitn_r + 4'h1;
                    end else if (scl_rise) begin
                        bitn_r <= 4'h9;
                        if (sda_l) begin
                            tw_st_r <= TW_IDLE;
                        end
                    end
                    if (scl_fall && bitn_r < 4'h8) begin
                        tw_oe_r <= ~sreg_r[7];
                    end else if (scl_fall && bitn_r == 4'h8) begin
                        tw_oe_r <= 1'b0;
                    end else if (scl_fall) begin
                        sreg_r  <= rd_byte;
                        addr_r  <= addr_r + 8'h01;
                        tw_oe_r <= ~rd_byte[7];
                        bitn_r  <= 4'h0;
                    end
                end
                default: tw_st_r <= TW_IDLE;
            endcase
        end
    end

    // write path: bytes queue here while the page buffer fills
    wire buf_pop = buf_out_valid & ~busy_r;

    dmsp_buf2 #(.W(8)) u_buf (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (buf_push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (byte_in),
        .out_valid_o (buf_out_valid),
        .out_ready_i (~busy_r),
        .out_data_o  (buf_out_data)
    );

    wire commit_go = pend_r & ~buf_out_valid;
    wire wr_done   = busy_r & (wr_cnt_r == WR_CYCLES - 1);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_r   <= 16'h0000;
            pbase_r  <= 8'h00;
            pspace_r <= 1'b0;
            plo_r    <= 4'h0;
        end else if (addr_ld) begin
            mask_r   <= 16'h0000;
            pbase_r  <= byte_in;
            pspace_r <= space_r;
            plo_r    <= byte_in[3:0];
        end else if (buf_pop) begin
            page_r[plo_r] <= buf_out_data;
            mask_r[plo_r] <= 1'b1;
            plo_r         <= plo_r + 4'h1;
        end else if (wr_done || (commit_go && !wr_ok)) begin
            mask_r <= 16'h0000;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r   <= 1'b0;
            busy_r   <= 1'b0;
            wr_cnt_r <= 32'h0000_0000;
        end else begin
            if (bus_stop && tw_run && (mask_r != 16'h0000 || buf_out_valid)) begin
                pend_r <= 1'b1;
            end else if (commit_go) begin
                pend_r   <= 1'b0;
                busy_r   <= wr_ok & (mask_r != 16'h0000);
                wr_cnt_r <= 32'h0000_0000;
            end
            if (busy_r) begin
                wr_cnt_r <= wr_cnt_r + 32'h0000_0001;
                busy_r   <= ~wr_done;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < int'(MEM_BYTES); i++) begin
                mem_r[i] <= init_byte(i);
            end
        end else if (wr_done) begin
            for (int j = 0; j < int'(PAGE_BYTES); j++) begin
                if (mask_r[j]) begin
                    mem_r[mem_idx(pspace_r, {pbase_r[7:4], 4'(j)})] <= page_r[j];
                end
            end
        end
    end

    // outputs
    assign sda_o        = 1'b0;
    assign sda_oe_o     = is_async ? at_oe_r : tw_oe_r;
    assign busy_o       = busy_r;
    assign async_mode_o = is_async;
    assign sync_mode_o  = (mode_r == MODE_SYNC);
endmodule

// ### src/dmsp_pkg.sv
package dmsp_pkg;

    // clock and timing
    localparam int unsigned CLK_MHZ       = 40;
    localparam int unsigned T_WR_US       = 5000;
    localparam int unsigned WR_CYCLES_DEF = T_WR_US * CLK_MHZ;
    localparam logic [8:0]  UNIT_CARRIER  = 9'h174;
    localparam logic [8:0]  ANS_DELAY     = 9'h190;
    localparam logic [3:0]  FRAME_BITS    = 4'hc;
    localparam logic [2:0]  ANS_LAST_BYTE = 3'h7;

    // memory organisation
    localparam int unsigned USER_BYTES = 256;
    localparam int unsigned CFG_BYTES  = 128;
    localparam int unsigned MEM_BYTES  = USER_BYTES + CFG_BYTES;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned ZONES      = 4;

    // configuration layout
    localparam int unsigned CFG_ANS     = 0;
    localparam int unsigned ANS_BYTES   = 8;
    localparam int unsigned CFG_ACCESS  = 8;
    localparam int unsigned CFG_PWD     = 16;
    localparam int unsigned PWD_SETS    = 8;
    localparam int unsigned PWD_BYTES   = 3;
    localparam int unsigned CFG_KEY     = 64;
    localparam int unsigned KEY_SETS    = 4;
    localparam int unsigned KEY_BYTES   = 8;
    localparam int unsigned ACC_RD_BIT  = 0;
    localparam int unsigned ACC_WR_BIT  = 1;
    localparam logic [7:0]  ACCESS_RST  = 8'h03;
    localparam logic [63:0] ANS_RST     = 64'h0011_2233_4455_663b;

    // device byte fields
    localparam int unsigned DEVB_ADDR_LO = 4;
    localparam int unsigned DEVB_SPACE   = 1;
    localparam int unsigned DEVB_RD      = 0;
    localparam logic [3:0]  DEV_ADDR_NONE = 4'hf;
    localparam logic [7:0]  READ_DENIED  = 8'hff;

    // pin order inside the sampler vector
    localparam int unsigned PIN_SCL = 0;
    localparam int unsigned PIN_SDA = 1;
    localparam int unsigned PIN_RST = 2;
    localparam logic [2:0]  PIN_RST_VAL = 3'h6;

    typedef enum logic [1:0] {
        MODE_NONE  = 2'b00,
        MODE_ASYNC = 2'b01,
        MODE_SYNC  = 2'b11
    } dmsp_mode_type;

    typedef enum logic [1:0] {
        TW_IDLE = 2'b00,
        TW_RX   = 2'b01,
        TW_TX   = 2'b11
    } dmsp_tw_type;

    typedef enum logic [1:0] {
        AT_IDLE = 2'b00,
        AT_WAIT = 2'b01,
        AT_SEND = 2'b11,
        AT_END  = 2'b10
    } dmsp_atr_type;

endpackage

// ### src/dmsp_sync3.sv
`timescale 1ns/10ps
module dmsp_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic d_i,
    output logic      lvl_o
);
    logic q1_r;
    logic q2_r;
    logic q3_r;

    // level changes only once stages two and three agree
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q1_r  <= RST_VAL;
            q2_r  <= RST_VAL;
            q3_r  <= RST_VAL;
            lvl_o <= RST_VAL;
        end else begin
            q1_r <= d_i;
            q2_r <= q1_r;
            q3_r <= q2_r;
            if (q2_r == q3_r) begin
                lvl_o <= q3_r;
            end
        end
    end
endmodule

// ### src/dmsp_buf2.sv
`timescale 1ns/10ps
module dmsp_buf2 #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    logic [W-1:0] data_r [0:1];
    logic [1:0]   cnt_r;
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    wire          push = in_valid_i & in_ready_o;
    wire          pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = data_r[rd_ptr_r];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r     <= 2'h0;
            wr_ptr_r  <= 1'b0;
            rd_ptr_r  <= 1'b0;
            data_r[0] <= '0;
            data_r[1] <= '0;
        end else begin
            if (push) begin
                data_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r         <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### test/dmsp_port_assertions.sv
`timescale 1ns/10ps
module dmsp_port_checker #(
    parameter int unsigned WR_CYCLES = 50
) (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       link_clk_i,
    input wire logic       rst_pin_i,
    input wire logic       sda_i,
    input wire logic [3:0] dev_addr_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       busy_o,
    input wire logic       async_mode_o,
    input wire logic       sync_mode_o
);
    import dmsp_pkg::*;
    logic [2:0]  scl_r;
    logic        oe_r;
    logic        seen_r;
    logic [15:0] ecnt_r;
    int unsigned bcnt_r;
    wire         edge_w = scl_r[1] & ~scl_r[2];
    wire         chg_w  = sda_oe_o != oe_r;
    // carrier edges between data line changes, cycles of busy
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {scl_r, oe_r, seen_r, ecnt_r, bcnt_r} <= '0;
        end else begin
            scl_r  <= {scl_r[1:0], link_clk_i};
            oe_r   <= sda_oe_o;
            seen_r <= seen_r | (chg_w & async_mode_o);
            ecnt_r <= chg_w ? 16'(edge_w) : ecnt_r + 16'(edge_w);
            bcnt_r <= busy_o ? bcnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    modes_excl_a: assert property (!(async_mode_o && sync_mode_o)) else $error("both modes");
    async_hold_a: assert property (async_mode_o |=> async_mode_o) else $error("mode lost");
    sync_hold_a: assert property (sync_mode_o |=> sync_mode_o) else $error("mode lost");
    drain_only_a: assert property (sda_o == 1'b0) else $error("data line driven high");
    unit_len_a: assert property (async_mode_o && chg_w && seen_r
        |-> ecnt_r != 0 && ecnt_r % UNIT_CARRIER == 0) else $error("bit length off");
    scl_low_a: assert property (sync_mode_o && $changed(sda_oe_o)
        |-> !link_clk_i) else $error("data change while clock high");
    busy_len_a: assert property ($fell(busy_o) |-> bcnt_r == WR_CYCLES)
        else $error("write cycle length off");
    busy_quiet_a: assert property (busy_o |-> !sda_oe_o) else $error("answer while busy");
    rst_abort_a: assert property (async_mode_o && !rst_pin_i [*8] |-> !sda_oe_o)
        else $error("sending while reset low");
    addr_none_a: assert property (dev_addr_i == DEV_ADDR_NONE
        |-> !(sync_mode_o && sda_oe_o)) else $error("unused address answered");
    cover property ($fell(busy_o));
    cover property (async_mode_o && $rose(sda_oe_o));
    cover property (sync_mode_o && $rose(sda_oe_o));
endmodule
bind dmsp_port dmsp_port_checker #(.WR_CYCLES(WR_CYCLES)) chk_i (.clk_i(clk_i),
    .resetn_i(resetn_i), .link_clk_i(link_clk_i), .rst_pin_i(rst_pin_i), .sda_i(sda_i),
    .dev_addr_i(dev_addr_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o),
    .async_mode_o(async_mode_o), .sync_mode_o(sync_mode_o));

// ### test/dmsp_host_model.sv
`timescale 1ns/10ps
module dmsp_host_model (
    input  wire logic clk_i,
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output logic      rst_o,
    output logic      sda_o
);
    import dmsp_pkg::*;
    logic pull_r;
    initial {scl_o, rst_o, pull_r} = 3'b110;
    assign sda_o = ~(pull_r | dev_oe_i);
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // data set in the low phase, read at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        scl_o <= 1'b0;
        w(3);
        pull_r <= ~b;
        w(5);
        scl_o <= 1'b1;
        w(8);
        r = sda_o;
    endtask
    // start is cond(0,1), stop is cond(1,0)
    task automatic cond(input logic p0, input logic p1);
        scl_o <= 1'b0;
        w(3);
        pull_r <= p0;
        w(5);
        scl_o <= 1'b1;
        w(4);
        pull_r <= p1;
        w(4);
    endtask
    task automatic tw_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic tw_read(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask
    task automatic reset_pulse();
        rst_o <= 1'b0;
        w(16);
        rst_o <= 1'b1;
        w(4);
    endtask
    // carrier of n rising edges, line read in the middle of each bit
    task automatic answer(input int n, output logic [11:0] f);
        for (int e = 1; e <= n; e++) begin
            scl_o <= 1'b0;
            w(4);
            scl_o <= 1'b1;
            w(4);
            if (e >= ANS_DELAY && (e - ANS_DELAY) % UNIT_CARRIER == 186)
                f[(e - ANS_DELAY) / UNIT_CARRIER] = sda_o;
        end
    endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
    import dmsp_pkg::*;
    localparam int unsigned WR = 400;
    logic       clk_i      = 1'b0;
    logic       resetn_i   = 1'b0;
    logic [3:0] dev_addr_i = 4'h5;
    logic       scl, rst_pin, sda, sda_o, sda_oe, busy, am, sm;
    int         errors, comparisons;
    always #12.5 clk_i = ~clk_i;
    dmsp_host_model host_i (.clk_i(clk_i), .dev_oe_i(sda_oe), .scl_o(scl), .rst_o(rst_pin),
        .sda_o(sda));
    dmsp_port #(.WR_CYCLES(WR)) dmsp_port_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .link_clk_i(scl), .rst_pin_i(rst_pin), .sda_i(sda), .dev_addr_i(dev_addr_i),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .busy_o(busy), .async_mode_o(am),
        .sync_mode_o(sm));
    function automatic logic [7:0] b0(logic [3:0] ad, logic sp, logic rd);
        return {ad, 4'h0} | (8'(sp) << DEVB_SPACE) | 8'(rd);
    endfunction
    task automatic reset_dut();
        resetn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wr(input logic sp, input logic [7:0] a, input int n,
                      input logic [23:0] d, input logic pl);
        logic k;
        host_i.cond(1'b0, 1'b1);
        host_i.tw_byte(b0(4'h5, sp, 1'b0), k);
        `CHK(k, 1'b1)
        host_i.tw_byte(a, k);
        for (int i = 0; i < n; i++) begin
            host_i.tw_byte(d[8*i +: 8], k);
            `CHK(k, 1'b1)
        end
        host_i.cond(1'b1, 1'b0);
        if (pl) begin
            host_i.cond(1'b0, 1'b1);
            host_i.tw_byte(b0(4'h5, sp, 1'b0), k);
            `CHK(k, 1'b0)
            `CHK(busy, 1'b1)
            host_i.cond(1'b1, 1'b0);
        end
        for (int i = 0; i < 2 * WR && busy !== 1'b0; i++) @(posedge clk_i);
        `CHK(busy, 1'b0)
    endtask
    task automatic rd1(input logic sp, input logic [7:0] a, input logic [7:0] e);
        logic       k;
        logic [7:0] v;
        host_i.cond(1'b0, 1'b1);
        host_i.tw_byte(b0(4'h5, sp, 1'b0), k);
        host_i.tw_byte(a, k);
        host_i.cond(1'b0, 1'b1);
        host_i.tw_byte(b0(4'h5, sp, 1'b1), k);
        host_i.tw_read(1'b1, v);
        host_i.cond(1'b1, 1'b0);
        `CHK(v, e)
    endtask
    task automatic t_answer();
        logic [11:0] f;
        host_i.reset_pulse();
        `CHK({am, sm}, 2'b10)
        host_i.answer(ANS_DELAY + 12 * UNIT_CARRIER, f);
        `CHK(f, {2'b11, ^ANS_RST[7:0], ANS_RST[7:0], 1'b0})
    endtask
    task automatic t_page();
        wr(1'b0, 8'h0f, 3, 24'hc3b2a1, 1'b1);
        `CHK({am, sm}, 2'b01)
        rd1(1'b0, 8'h0f, 8'ha1);
        rd1(1'b0, 8'h10, 8'h00);
        rd1(1'b0, 8'h00, 8'hb2);
        rd1(1'b0, 8'h01, 8'hc3);
    endtask
    task automatic t_zone();
        wr(1'b1, 8'h09, 1, 24'h0, 1'b1);
        wr(1'b0, 8'h40, 1, 24'h55, 1'b0);
        rd1(1'b0, 8'h40, READ_DENIED);
        rd1(1'b0, 8'h01, 8'hc3);
        wr(1'b1, 8'h5f, 1, 24'h24, 1'b1);
        rd1(1'b1, 8'h5f, 8'h24);
        rd1(1'b1, 8'h3f, 8'h00);
    endtask
    task automatic t_addr();
        logic k;
        host_i.cond(1'b0, 1'b1);
        host_i.tw_byte(b0(4'h6, 1'b0, 1'b0), k);
        `CHK(k, 1'b0)
        host_i.cond(1'b1, 1'b0);
        dev_addr_i <= DEV_ADDR_NONE;
        host_i.cond(1'b0, 1'b1);
        host_i.tw_byte(b0(DEV_ADDR_NONE, 1'b0, 1'b0), k);
        `CHK(k, 1'b0)
        host_i.cond(1'b1, 1'b0);
        dev_addr_i <= 4'h5;
    endtask
    task automatic t_no_answer();
        logic [11:0] f;
        host_i.reset_pulse();
        host_i.answer(600, f);
        `CHK(f[0], 1'b1)
        `CHK({am, sm}, 2'b01)
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2_400_000;
        errors++;
        wrap_up();
    end
    initial begin
        reset_dut();
        t_answer();
        reset_dut();
        t_page();
        t_zone();
        t_addr();
        t_no_answer();
        wrap_up();
    end
endmodule
